// *** inc/hbs_pkg.sv ***
package hbs_pkg;

    // Bus and counting widths
    localparam int          HBS_DW              = 32;
    localparam int          HBS_AW              = 8;
    localparam int          HBS_MSW             = 16;

    // Register byte offsets
    localparam logic [7:0]  HBS_OFF_CTRL        = 8'h00;
    localparam logic [7:0]  HBS_OFF_ON_DLY      = 8'h04;
    localparam logic [7:0]  HBS_OFF_OFF_DLY     = 8'h08;
    localparam logic [7:0]  HBS_OFF_STATUS      = 8'h0c;

    // Control field positions
    localparam int          HBS_CTRL_VARIANT    = 0;

    // Status field positions
    localparam int          HBS_ST_RELEASE      = 0;
    localparam int          HBS_ST_DRIVE        = 1;
    localparam int          HBS_ST_ENABLE       = 2;
    localparam int          HBS_ST_STATE_LSB    = 4;

    // Reset values
    localparam logic [15:0] HBS_ON_DLY_RST      = 16'h0064;
    localparam logic [15:0] HBS_OFF_DLY_RST     = 16'h0064;
    localparam logic        HBS_VARIANT_RST     = 1'b0;

    // Timing: clock rate and one millisecond
    localparam int          HBS_CLK_HZ          = 10_000_000;
    localparam int          HBS_MS_PER_S        = 1000;
    localparam int          HBS_CYC_PER_MS      = HBS_CLK_HZ / HBS_MS_PER_S;

    // Sequencer states
    typedef enum logic [1:0] {
        HBS_IDLE    = 2'b00,
        HBS_ON_WAIT = 2'b01,
        HBS_RUN     = 2'b10,
        HBS_OFF_WAIT= 2'b11
    } hbs_state_t;

    // Delay settings carried together
    typedef struct packed {
        logic        variant;
        logic [15:0] on_delay;
        logic [15:0] off_delay;
    } hbs_cfg_t;

endpackage : hbs_pkg

// *** rtl/hbs_ms_tick.sv ***
`timescale 1ns/1ps
`default_nettype none
module hbs_ms_tick
    import hbs_pkg::*;
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Restart and tick
    input  wire logic restart,
    output logic      tick
);

    localparam logic [13:0] LAST = 14'(HBS_CYC_PER_MS - 1);

    logic [13:0] cnt;
    wire         at_end = (cnt == LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt  <= 14'h0000;
            tick <= 1'b0;
        end else begin
            cnt  <= (restart || at_end) ? 14'h0000 : cnt + 14'h0001;
            tick <= at_end && !restart;
        end
    end

endmodule : hbs_ms_tick
`default_nettype wire

// *** rtl/hbs_sequencer.sv ***
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Release low means brake engaged, locked
// - Release high means brake freed
// - Separate on and off delay settings
// - Disable without variant: release drops after off delay
// - Variant: drive removed after off delay
// - Without variant, brake engages only after servo off
// - Delays in ms, default 100
module hbs_sequencer
    import hbs_pkg::*;
(
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [HBS_AW-1:0] paddr,
    input  wire logic [HBS_DW-1:0] pwdata,
    output logic      [HBS_DW-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Servo enable pin
    input  wire logic              servo_enable_in,
    // Brake and drive outputs
    output logic                   brake_release_out,
    output logic                   motor_drive_out
);

    ////////////////////////////////////////////////////////////////////
    // Pin synchroniser
    logic [2:0] en_sync;
    logic       en_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_sync <= 3'b000;
            en_q    <= 1'b0;
        end else begin
            en_sync <= {en_sync[1:0], servo_enable_in};
            if (en_sync[1] == en_sync[2]) begin
                en_q <= en_sync[2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // APB registers
    hbs_cfg_t   cfg;
    hbs_state_t state;

    wire setup_ok = psel && !penable;
    wire access   = psel && penable;
    wire hit_ctrl = (paddr == HBS_OFF_CTRL);
    wire hit_on   = (paddr == HBS_OFF_ON_DLY);
    wire hit_off  = (paddr == HBS_OFF_OFF_DLY);
    wire hit_st   = (paddr == HBS_OFF_STATUS);
    wire hit_any  = hit_ctrl || hit_on || hit_off || hit_st;
    wire wr_en    = access && pwrite && hit_any;

    logic [HBS_DW-1:0] status_word;
    logic [HBS_DW-1:0] rd_mux;

    always_comb begin
        status_word = '0;
        status_word[HBS_ST_RELEASE] = brake_release_out;
        status_word[HBS_ST_DRIVE]   = motor_drive_out;
        status_word[HBS_ST_ENABLE]  = en_q;
        status_word[HBS_ST_STATE_LSB +: 2] = state;
    end

    assign rd_mux = hit_ctrl ? {31'h00000000, cfg.variant} :
                    hit_on   ? {16'h0000, cfg.on_delay} :
                    hit_off  ? {16'h0000, cfg.off_delay} :
                    hit_st   ? status_word : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg.variant   <= HBS_VARIANT_RST;
            cfg.on_delay  <= HBS_ON_DLY_RST;
            cfg.off_delay <= HBS_OFF_DLY_RST;
        end else if (wr_en) begin
            if (hit_ctrl) cfg.variant  <= pwdata[HBS_CTRL_VARIANT];
            if (hit_on)   cfg.on_delay <= pwdata[15:0];
            if (hit_off)  cfg.off_delay <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setup_ok;
            pslverr <= setup_ok && !(paddr inside {HBS_OFF_CTRL, HBS_OFF_ON_DLY,
                                                   HBS_OFF_OFF_DLY, HBS_OFF_STATUS});
            prdata  <= (setup_ok && !pwrite) ? rd_mux : 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Millisecond timebase
    logic restart;
    logic tick;

    hbs_ms_tick u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .restart (restart),
        .tick    (tick)
    );

    ////////////////////////////////////////////////////////////////////
    // Sequencer
    hbs_state_t       next_state;
    logic [15:0]      ms_cnt;
    logic [15:0]      next_ms_cnt;
    logic             next_release;
    logic             next_drive;
    wire              on_done  = (ms_cnt >= cfg.on_delay);
    wire              off_done = (ms_cnt >= cfg.off_delay);

    always_comb begin
        next_state   = state;
        next_ms_cnt  = tick ? ms_cnt + 16'h0001 : ms_cnt;
        next_release = brake_release_out;
        next_drive   = motor_drive_out;
        restart      = 1'b0;
        case (state)
            HBS_IDLE: begin
                next_release = 1'b0;
                next_drive   = 1'b0;
                next_ms_cnt  = 16'h0000;
                restart      = 1'b1;
                if (en_q) begin
                    next_state = HBS_ON_WAIT;
                    next_drive = 1'b1;
                end
            end
            HBS_ON_WAIT: begin
                if (!en_q) begin
                    next_state = HBS_IDLE;
                    next_drive = 1'b0;
                end else if (on_done) begin
                    next_release = 1'b1;
                    next_state   = HBS_RUN;
                end
            end
            HBS_RUN: begin
                next_ms_cnt = 16'h0000;
                restart     = 1'b1;
                if (!en_q) begin
                    next_state = HBS_OFF_WAIT;
                    if (cfg.variant) next_release = 1'b0;
                    else             next_drive   = 1'b0;
                end
            end
            HBS_OFF_WAIT: begin
                if (off_done) begin
                    next_release = 1'b0;
                    next_drive   = 1'b0;
                    next_state   = HBS_IDLE;
                end
            end
            default: begin
                next_state   = HBS_IDLE;
                next_release = 1'b0;
                next_drive   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state             <= HBS_IDLE;
            ms_cnt            <= 16'h0000;
            brake_release_out <= 1'b0;
            motor_drive_out   <= 1'b0;
        end else begin
            state             <= next_state;
            ms_cnt            <= next_ms_cnt;
            brake_release_out <= next_release;
            motor_drive_out   <= next_drive;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_disable;
        state == HBS_RUN && !en_q;
    endsequence

    a_idle_brake_held: assert property (@(posedge pclk) disable iff (!presetn)
        state == HBS_IDLE |=> !brake_release_out)
        else $error("Brake released while idle");

    a_release_needs_en: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(brake_release_out) |-> $past(state) == HBS_ON_WAIT && motor_drive_out)
        else $error("Release without enable wait");

    a_off_wait_holds: assert property (@(posedge pclk) disable iff (!presetn)
        s_disable ##1 (!cfg.variant && !off_done) |-> brake_release_out)
        else $error("Brake engaged before off delay");

    a_variant_order: assert property (@(posedge pclk) disable iff (!presetn)
        s_disable ##0 cfg.variant |=> !brake_release_out && motor_drive_out)
        else $error("Variant disable order wrong");

    a_drive_first: assert property (@(posedge pclk) disable iff (!presetn)
        s_disable ##0 !cfg.variant |=> brake_release_out && !motor_drive_out)
        else $error("Drive not removed before brake");

    a_on_delay_min: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(brake_release_out) |-> $past(ms_cnt) >= cfg.on_delay)
        else $error("Release before on delay");

    a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready)
        else $error("APB ready missing");

    a_reset_default: assert property (@(posedge pclk)
        $rose(presetn) |-> cfg.on_delay == HBS_ON_DLY_RST && cfg.off_delay == HBS_OFF_DLY_RST)
        else $error("Delay defaults wrong");

endmodule : hbs_sequencer
`default_nettype wire

// *** sim/hbs_servo_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module hbs_servo_ctrl (
    // Clock
    input  wire logic pclk,
    // Command and brake coil
    input  wire logic enable_cmd,
    input  wire logic brake_release_out,
    output logic      servo_enable_in,
    output logic      brake_engaged
);
    ////////////////////////////////////////////////////////////////
    // brake follows release output only
    assign brake_engaged = ~brake_release_out;
    // Enable changes just after an edge
    always @(posedge pclk) begin
        servo_enable_in <= enable_cmd;
    end
endmodule : hbs_servo_ctrl
`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench import hbs_pkg::*;;
    localparam int     C = HBS_CYC_PER_MS;
    logic              pclk    = 1'b0;
    logic              presetn = 1'b0;
    logic              psel    = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite  = 1'b0;
    logic [HBS_AW-1:0] paddr   = '0;
    logic [HBS_DW-1:0] pwdata  = '0;
    logic [HBS_DW-1:0] prdata;
    logic [31:0]       rd;
    logic              pready, pslverr, sen, rel, drv, brk, er;
    logic              en_cmd  = 1'b0;
    int                err_count = 0;
    int                comparisons = 0;
    int                n, d;
    // Variant, on delay, off delay, drive drops first
    logic [15:0]       rows [3][4] = '{'{0, 1, 1, 1}, '{1, 0, 1, 0}, '{0, 0, 2, 1}};
    ////////////////////////////////////////////////////////////////
    always #50 pclk = ~pclk;
    hbs_sequencer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .servo_enable_in(sen), .brake_release_out(rel),
        .motor_drive_out(drv));
    hbs_servo_ctrl ctrl (.pclk(pclk), .enable_cmd(en_cmd), .brake_release_out(rel),
        .servo_enable_in(sen), .brake_engaged(brk));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_lvl(input logic sel, input logic want, input int lim);
        n = 0;
        while ((sel ? drv : rel) !== want && n < lim) begin
            @(posedge pclk);
            n++;
        end
    endtask : wait_lvl
    task automatic stop_test();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////////
    initial begin
        #9_000_000;
        err_count++;
        stop_test();
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, HBS_OFF_ON_DLY, 0);
        chk("on delay", 32'h64, rd);
        apb(0, HBS_OFF_OFF_DLY, 0);
        chk("off delay", 32'h64, rd);
        apb(0, 8'h10, 0);
        chk("unmapped", 32'h1, {31'h0, er});
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            apb(1, HBS_OFF_CTRL, {16'h0, rows[i][0]});
            apb(1, HBS_OFF_ON_DLY, {16'h0, rows[i][1]});
            apb(1, HBS_OFF_OFF_DLY, {16'h0, rows[i][2]});
            en_cmd <= 1'b1;
            wait_lvl(1, 1, 20);
            chk("drive on", 1, drv);
            chk("release at drive on", 0, rel);
            wait_lvl(0, 1, 4 * C);
            d = int'(rows[i][1]);
            chk("on wait", 1, n >= d * C - 20 && n <= (d + 1) * C + 20);
            apb(0, HBS_OFF_STATUS, 0);
            chk("status run", 32'h27, rd);
            en_cmd <= 1'b0;
            wait_lvl(rows[i][3][0], 0, 20);
            chk("first one down", 0, rows[i][3][0] ? drv : rel);
            chk("later one still up", 1, rows[i][3][0] ? rel : drv);
            wait_lvl(~rows[i][3][0], 0, 4 * C);
            d = int'(rows[i][2]);
            chk("off wait", 1, n >= d * C - 20 && n <= (d + 1) * C + 20);
            chk("brake coil", 1, brk);
            $display("test row %0d done", i);
        end
        apb(1, HBS_OFF_CTRL, 0);
        apb(1, HBS_OFF_ON_DLY, 1);
        en_cmd <= 1'b1;
        wait_lvl(1, 1, 20);
        en_cmd <= 1'b0;
        wait_lvl(1, 0, 20);
        chk("abort drive", 0, drv);
        wait_lvl(0, 1, C + 100);
        chk("abort release", 0, rel);
        $display("test abort done");
        apb(1, HBS_OFF_ON_DLY, 0);
        en_cmd <= 1'b1;
        wait_lvl(0, 1, 40);
        chk("release before reset", 1, rel);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("release in reset", 0, rel);
        chk("drive in reset", 0, drv);
        presetn <= 1'b1;
        en_cmd  <= 1'b0;
        apb(0, HBS_OFF_ON_DLY, 0);
        chk("on delay after reset", 32'h64, rd);
        chk("release after reset", 0, rel);
        $display("test mid reset done");
        stop_test();
    end
endmodule : testbench
`default_nettype wire
